// ==== pkg/fieldbus_gateway_pkg.sv ====
// Purpose: Shared constants and types of the fieldbus gateway.
// Assumes: Image byte k sits at bits [8k+7:8k]; slave s data at [4s+3:4s].
// Notes: Slave 0 does not exist on the field network; its slot stays empty.
package fieldbus_gateway_pkg;
	localparam int NUM_SLAVES = 32;
	localparam int IMG_BYTES = 16;
	localparam int IMG_BITS = 128;
	localparam int DIAG_BITS = 256;
	localparam int PRM_LEN = 7;
	localparam int CFG_LEN = 20;
	localparam int DIAG_FAIL_BYTE = 0;
	localparam int DIAG_CFG_BYTE = 16;
	localparam int EVEN_NIB_LSB = 4;
	localparam int ODD_NIB_LSB = 0;
	localparam int LAST_SLOT = 31;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_WIDTH = 11;
	localparam logic [3:0] PRM_DEFAULT = 4'hF;
	localparam logic [31:0] SLAVE_MASK = 32'hFFFF_FFFE;
	// Input-bit mask per type code, code 0 in the lowest nibble
	localparam logic [63:0] IN_MASK_TABLE = 64'h0000_0000_0137_FFFF;

	typedef enum logic [1:0] {
		MSG_PRM = 2'b00,
		MSG_CFG = 2'b01,
		MSG_DATA = 2'b10,
		MSG_OTHER = 2'b11
	} msgKind_t;

	typedef struct packed {
		msgKind_t kind;
		logic last;
		logic [7:0] data;
	} msgWord_t;

	typedef enum logic [2:0] {
		ST_SCAN = 3'b000,
		ST_BCAST = 3'b001,
		ST_WAIT_PRM = 3'b010,
		ST_WAIT_CFG = 3'b011,
		ST_EXCH = 3'b100
	} gwState_t;

	// Which of a slave's four bits are inputs
	function automatic logic [3:0] inMask(input logic [3:0] code);
		return IN_MASK_TABLE[{code, 2'b00} +: 4];
	endfunction

	// Lowest bit of a slave's nibble within the 16-byte image
	function automatic logic [6:0] nibPos(input int s);
		return 7'((s / 2) * 8 + ((s % 2) == 1 ? ODD_NIB_LSB : EVEN_NIB_LSB));
	endfunction
endpackage

// ==== rtl/fieldbus_gateway.sv ====
// Purpose: Default start-up of a gateway from a field network to DP images.
// Assumes: Field scan logic and message framer run on clk; no sync needed.
// Notes: Images and diagnostics are presented as parallel registered words.
// Notes on behaviour
// R1 - Master handles 20-byte config, 7-byte param, 32-byte diag messages.
// R2 - Cyclic image is exactly 16 input bytes and 16 output bytes.
// R3 - A slave's image position depends only on its network address.
// R4 - Slave type code decides which nibble bits are inputs or outputs.
// R5 - At start-up parameter value F goes to every connected slave.
// R6 - Slaves found at start-up become actual and setpoint configuration.
// R7 - Each restart replaces the setpoint with the slaves present then.
// R8 - Diagnostic bytes 16 to 19 carry the actual configuration.
// R9 - Even-numbered slaves occupy bits 4 to 7 of their byte.
// R10 - Odd-numbered slaves occupy bits 0 to 3 of their byte.
// R11 - Byte k holds slaves 2k and 2k+1; last byte holds 30 and 31.
// R12 - After parameters arrive, added or removed slaves are ignored.
// R13 - Setpoint slaves later removed are flagged failed in diagnostics.
// R14 - Scan the network first, then await parameter then config message.
// R15 - Parameter message is exactly the seven standard bytes 0 to 6.
// R16 - Config message must be exactly 20 bytes long.
// R17 - Operator changes slaves first, then triggers a new start-up.
// R18 - No cyclic exchange until parameter and config messages are accepted.
`timescale 1ns/100ps

module gw_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic clkEn,
	input wire logic rst,
	input wire logic inValid,
	input wire logic [WIDTH-1:0] inData,
	output logic inReady,
	output logic outValid,
	output logic [WIDTH-1:0] outData,
	input wire logic outReady
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
	logic [AW:0] count_q, count_d;
	logic ready_q, ready_d;
	logic push, pop;

	// Ready is kept as a flop so the source never sees a combinational path
	always_comb begin
		push = inValid && ready_q;
		pop = outValid && outReady;
		wrPtr_d = push ? wrPtr_q + AW'(1) : wrPtr_q;
		rdPtr_d = pop ? rdPtr_q + AW'(1) : rdPtr_q;
		count_d = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		ready_d = count_d != (AW + 1)'(DEPTH);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
			ready_q <= 1'b0;
		end else if (clkEn) begin
			wrPtr_q <= wrPtr_d;
			rdPtr_q <= rdPtr_d;
			count_q <= count_d;
			ready_q <= ready_d;
		end
	end

	// Storage needs no reset; a slot is only popped after it has been written
	always_ff @(posedge clk) begin
		if (clkEn && push) begin
			mem[wrPtr_q] <= inData;
		end
	end

	assign inReady = ready_q;
	assign outValid = count_q != '0;
	assign outData = mem[rdPtr_q];

	fifo_bound_a: assert property (@(posedge clk) disable iff (rst)
		count_q <= (AW + 1)'(DEPTH))
		else $error("fifo count above depth");
endmodule

module fieldbus_gateway
	import fieldbus_gateway_pkg::*;
(
	input wire logic clk,
	input wire logic clkEn,
	input wire logic rst,
	input wire logic restart,
	input wire logic [NUM_SLAVES-1:0] fieldPresent,
	input wire logic [4*NUM_SLAVES-1:0] fieldIoCode,
	input wire logic [4*NUM_SLAVES-1:0] fieldIn,
	output logic [4*NUM_SLAVES-1:0] fieldOut,
	output logic prmReq,
	output logic [4:0] prmAddr,
	output logic [3:0] prmValue,
	input wire logic prmAck,
	input wire logic msgValid,
	input wire msgWord_t msgWord,
	output logic msgReady,
	output logic [IMG_BITS-1:0] dpInImage,
	output logic [DIAG_BITS-1:0] diagImage,
	output logic exchActive,
	output logic lengthError
);
	gwState_t state_q, state_d;
	logic [4:0] slot_q, slot_d;
	logic [NUM_SLAVES-1:0] setpoint_q, setpoint_d;
	logic [4:0] byteCnt_q, byteCnt_d;
	logic [IMG_BITS-1:0] outImage_q, outImage_d;
	logic [IMG_BITS-1:0] dpIn_q, dpIn_d;
	logic [4*NUM_SLAVES-1:0] fieldOut_q, fieldOut_d;
	logic [DIAG_BITS-1:0] diag_q, diag_d;
	logic prmReq_q, prmReq_d, lenErr_q, lenErr_d, exch_q;
	logic [3:0] prmVal_q;
	logic fValid, fReady, pop, popLast;
	logic [FIFO_WIDTH-1:0] fData;
	msgWord_t fWord;
	logic [5:0] msgLen;
	logic [NUM_SLAVES-1:0] failNow;

	// Messages wait here while the gateway scans or broadcasts
	gw_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) msgFifo (
		.clk(clk),
		.clkEn(clkEn),
		.rst(rst),
		.inValid(msgValid),
		.inData(msgWord),
		.inReady(msgReady),
		.outValid(fValid),
		.outData(fData),
		.outReady(fReady)
	);

	// The parser only drains in states that expect messages
	always_comb begin
		fWord = msgWord_t'(fData);
		fReady = (state_q == ST_WAIT_PRM) || (state_q == ST_WAIT_CFG) ||
			(state_q == ST_EXCH); // R14
		pop = fValid && fReady;
		popLast = pop && fWord.last;
		msgLen = {1'b0, byteCnt_q} + 6'd1;
		failNow = setpoint_q & ~fieldPresent & SLAVE_MASK;
	end

	// Start-up sequencer and message parser
	always_comb begin
		state_d = state_q;
		slot_d = slot_q;
		setpoint_d = setpoint_q;
		outImage_d = outImage_q;
		prmReq_d = prmReq_q;
		lenErr_d = 1'b0;
		byteCnt_d = byteCnt_q;
		if (pop) begin
			byteCnt_d = fWord.last ? 5'd0 :
				(byteCnt_q == 5'd31 ? byteCnt_q : byteCnt_q + 5'd1);
		end
		case (state_q)
			ST_SCAN: begin
				setpoint_d = fieldPresent & SLAVE_MASK; // R6 R7
				slot_d = 5'd1;
				state_d = ST_BCAST;
			end
			ST_BCAST: begin
				if (prmReq_q) begin
					if (prmAck) begin
						prmReq_d = 1'b0;
						slot_d = slot_q + 5'd1;
						if (slot_q == 5'(LAST_SLOT)) begin
							state_d = ST_WAIT_PRM;
						end
					end
				end else if (setpoint_q[slot_q]) begin
					prmReq_d = 1'b1; // R5
				end else begin
					slot_d = slot_q + 5'd1;
					if (slot_q == 5'(LAST_SLOT)) begin
						state_d = ST_WAIT_PRM; // R14
					end
				end
			end
			ST_WAIT_PRM: begin
				if (popLast && fWord.kind == MSG_PRM) begin
					if (msgLen == 6'(PRM_LEN)) begin
						state_d = ST_WAIT_CFG; // R15 R12
					end else begin
						lenErr_d = 1'b1;
					end
				end
			end
			ST_WAIT_CFG: begin
				if (popLast && fWord.kind == MSG_CFG) begin
					if (msgLen == 6'(CFG_LEN)) begin
						state_d = ST_EXCH; // R16
					end else begin
						lenErr_d = 1'b1;
					end
				end
			end
			ST_EXCH: begin
				if (pop && fWord.kind == MSG_DATA) begin
					if (byteCnt_q < 5'(IMG_BYTES)) begin
						outImage_d[{byteCnt_q[3:0], 3'b000} +: 8] = fWord.data; // R2
					end
					if (fWord.last && msgLen != 6'(IMG_BYTES)) begin
						lenErr_d = 1'b1;
					end
				end
			end
			default: begin
				state_d = ST_SCAN;
			end
		endcase
		// A restart rebuilds the setpoint from whatever is present then
		if (restart) begin
			state_d = ST_SCAN; // R7
			prmReq_d = 1'b0;
			outImage_d = '0;
			byteCnt_d = 5'd0;
		end
	end

	// Image mapping; slaves outside the frozen setpoint carry no data
	always_comb begin
		logic [3:0] mask;
		logic [6:0] pos;
		logic act;
		mask = 4'h0;
		pos = 7'd0;
		act = 1'b0;
		dpIn_d = '0;
		fieldOut_d = '0;
		for (int s = 1; s < NUM_SLAVES; s++) begin
			mask = inMask(fieldIoCode[4*s +: 4]); // R4
			pos = nibPos(s); // R3 R9 R10 R11
			act = setpoint_q[s] && fieldPresent[s]; // R12
			if (act && exch_q) begin
				dpIn_d[pos +: 4] = fieldIn[4*s +: 4] & mask; // R18
				fieldOut_d[4*s +: 4] = outImage_q[pos +: 4] & ~mask; // R4
			end
		end
	end

	// Diagnostics: failed slaves up front, actual configuration in the back
	always_comb begin
		diag_d = '0;
		diag_d[8*DIAG_FAIL_BYTE +: NUM_SLAVES] = failNow; // R13
		diag_d[8*DIAG_CFG_BYTE +: NUM_SLAVES] = fieldPresent & SLAVE_MASK; // R8
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_SCAN;
			slot_q <= 5'd0;
			setpoint_q <= '0;
			byteCnt_q <= 5'd0;
			outImage_q <= '0;
			dpIn_q <= '0;
			fieldOut_q <= '0;
			diag_q <= '0;
			prmReq_q <= 1'b0;
			prmVal_q <= PRM_DEFAULT;
			lenErr_q <= 1'b0;
			exch_q <= 1'b0;
		end else if (clkEn) begin
			state_q <= state_d;
			slot_q <= slot_d;
			setpoint_q <= setpoint_d;
			byteCnt_q <= byteCnt_d;
			outImage_q <= outImage_d;
			dpIn_q <= dpIn_d;
			fieldOut_q <= fieldOut_d;
			diag_q <= diag_d;
			prmReq_q <= prmReq_d;
			prmVal_q <= PRM_DEFAULT; // R5
			lenErr_q <= lenErr_d;
			exch_q <= state_d == ST_EXCH; // R18
		end
	end

	assign fieldOut = fieldOut_q;
	assign prmReq = prmReq_q;
	assign prmAddr = slot_q;
	assign prmValue = prmVal_q;
	assign dpInImage = dpIn_q;
	assign diagImage = diag_q;
	assign exchActive = exch_q;
	assign lengthError = lenErr_q;

	// Checks on the behaviour above
	prm_value_a: assert property (@(posedge clk) disable iff (rst) // R5
		prmReq |-> prmValue == 4'hF && setpoint_q[prmAddr])
		else $error("parameter sent with wrong value or to absent slave");

	bcast_hold_a: assert property (@(posedge clk) disable iff (rst) // R5
		prmReq && !prmAck && clkEn && !restart |=> prmReq && $stable(prmAddr))
		else $error("parameter request dropped before acknowledge");

	setpoint_cap_a: assert property (@(posedge clk) disable iff (rst) // R6
		state_q == ST_SCAN && clkEn && !restart |=>
		setpoint_q == ($past(fieldPresent) & SLAVE_MASK) &&
		state_q == ST_BCAST)
		else $error("setpoint not captured at start-up");

	setpoint_frz_a: assert property (@(posedge clk) disable iff (rst) // R12
		(state_q == ST_WAIT_CFG || state_q == ST_EXCH) && !restart |=>
		$stable(setpoint_q))
		else $error("setpoint changed after parameter message");
	fail_diag_a: assert property (@(posedge clk) disable iff (rst) // R13
		clkEn |=> diagImage[31:0] == $past(failNow))
		else $error("failed slaves not reported");
	cfg_diag_a: assert property (@(posedge clk) disable iff (rst) // R8
		clkEn |=> diagImage[159:128] == ($past(fieldPresent) & SLAVE_MASK))
		else $error("actual configuration missing from diagnostics");
	prm_len_a: assert property (@(posedge clk) disable iff (rst) // R15
		state_q == ST_WAIT_PRM && popLast && fWord.kind == MSG_PRM &&
		msgLen != 6'd7 && clkEn && !restart |=>
		lengthError && state_q == ST_WAIT_PRM)
		else $error("bad parameter length accepted");
	cfg_len_a: assert property (@(posedge clk) disable iff (rst) // R16
		state_q == ST_WAIT_CFG && popLast && fWord.kind == MSG_CFG &&
		clkEn && !restart |=> exchActive == ($past(msgLen) == 6'd20))
		else $error("config length check wrong");
	exch_gate_a: assert property (@(posedge clk) disable iff (rst) // R18
		!exchActive |=> dpInImage == '0 && fieldOut == '0)
		else $error("image exchanged before start-up completed");
	slot_odd_a: assert property (@(posedge clk) disable iff (rst) // R10
		exchActive && clkEn && setpoint_q[1] && fieldPresent[1] |=>
		dpInImage[3:0] == ($past(fieldIn[7:4]) &
		inMask($past(fieldIoCode[7:4]))))
		else $error("slave 1 not in low nibble of byte 0");
	slot_last_a: assert property (@(posedge clk) disable iff (rst) // R11
		exchActive && clkEn && setpoint_q[30] && fieldPresent[30] |=>
		dpInImage[127:124] == ($past(fieldIn[123:120]) &
		inMask($past(fieldIoCode[123:120]))) && dpInImage[7:4] == 4'h0)
		else $error("slave 30 not in high nibble of last byte");
endmodule

// ==== test/field_partner.sv ====
// Purpose: Field-side model that answers the gateway's parameter requests.
// Assumes: One request at a time, held until acknowledged.
// Notes: slow adds wait cycles, as a lagging field network would.
`timescale 1ns/100ps
module field_partner(
	input wire logic clk,
	input wire logic rst,
	input wire logic slow,
	input wire logic prmReq,
	input wire logic [4:0] prmAddr,
	input wire logic [3:0] prmValue,
	output logic prmAck
);
	logic [4:0] seen[$];
	int badValue = 0;
	int waitCnt = 0;
	// Log each accepted request; the ack is one cycle so none is taken twice
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			prmAck <= 1'b0;
			waitCnt <= 0;
		end else if (prmAck) begin
			prmAck <= 1'b0;
			seen.push_back(prmAddr);
			if (prmValue !== 4'hF) badValue++;
		end else if (prmReq === 1'b1 && waitCnt >= (slow ? 4 : 0)) begin
			prmAck <= 1'b1;
			waitCnt <= 0;
		end else if (prmReq === 1'b1)
			waitCnt <= waitCnt + 1;
	end
endmodule

// ==== test/tb.sv ====
// Purpose: Self-checking bench for the gateway default start-up.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: Image expectations are rebuilt from slave address and type code.
`timescale 1ns/100ps
module tb
	import fieldbus_gateway_pkg::*;
;
	logic clk = 0, rst = 1, clkEn = 1, restart = 0, slow = 0;
	logic msgValid = 0, msgReady, prmReq, prmAck, exchActive, lengthError;
	logic [4:0] prmAddr;
	logic [3:0] prmValue;
	logic [31:0] present = '0, setp = '0;
	logic [127:0] ioCode = '0, fin = '0, fieldOut, dpIn;
	logic [255:0] diag;
	logic [7:0] bytes [20];
	msgWord_t word = '0;
	int errors = 0, total_checks = 0, lenErrs = 0, sawFull = 0;

	always #2 clk = ~clk;

	fieldbus_gateway i_fieldbus_gateway (.clk(clk), .clkEn(clkEn),
		.rst(rst), .restart(restart), .fieldPresent(present),
		.fieldIoCode(ioCode), .fieldIn(fin), .fieldOut(fieldOut),
		.prmReq(prmReq), .prmAddr(prmAddr), .prmValue(prmValue),
		.prmAck(prmAck), .msgValid(msgValid), .msgWord(word),
		.msgReady(msgReady), .dpInImage(dpIn), .diagImage(diag),
		.exchActive(exchActive), .lengthError(lengthError));

	field_partner i_field_partner (.clk(clk), .rst(rst), .slow(slow),
		.prmReq(prmReq), .prmAddr(prmAddr), .prmValue(prmValue),
		.prmAck(prmAck));

	// Length errors are single-cycle pulses, so count them as they pass
	always @(posedge clk) if (lengthError === 1'b1) lenErrs++;

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input logic [255:0] got, exp, input string what);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask

	// Input bits of a slave by its type code
	function automatic logic [3:0] maskOf(input logic [3:0] c);
		case (c)
			4'h0, 4'h1, 4'h2, 4'h3: return 4'hF;
			4'h4: return 4'h7;
			4'h5: return 4'h3;
			4'h6: return 4'h1;
			default: return 4'h0;
		endcase
	endfunction

	// Each word is held until the edge that samples msgReady high
	task automatic sendMsg(input msgKind_t k, input int n);
		int w;
		for (int i = 0; i < n; i++) begin
			msgValid = 1;
			word = '{k, 1'(i == n - 1), bytes[i]};
			w = 0;
			do begin
				@(posedge clk);
				w++;
				if (msgReady !== 1'b1) sawFull = 1;
			end while (msgReady !== 1'b1 && w < 2000);
			#1;
		end
		msgValid = 0;
		// Let one edge pass idle so a following message always re-raises valid
		tick(1);
	endtask

	task automatic checkBcast();
		int w;
		int q[$];
		w = 0;
		for (int s = 1; s < 32; s++) if (setp[s]) q.push_back(s);
		while (i_field_partner.seen.size() < q.size() && w++ < 3000) tick(1);
		// Absent slots after the last ack still take a cycle each; queued
		// messages need time to drain once the sweep ends
		tick(32);
		chk(i_field_partner.seen.size(), q.size(), "broadcast count");
		foreach (q[i]) chk(i_field_partner.seen[i], q[i], "order");
		chk(i_field_partner.badValue, 0, "broadcast value");
	endtask

	// Random inputs and one data message, then both images against the model
	task automatic imageRound();
		logic [127:0] ei, eo;
		int p;
		fin = {$urandom, $urandom, $urandom, $urandom};
		for (int k = 0; k < 16; k++) bytes[k] = 8'($urandom);
		sendMsg(MSG_DATA, 16);
		tick(8);
		ei = '0;
		eo = '0;
		for (int s = 1; s < 32; s++) begin
			p = (s % 2) ? 0 : 4;
			if (setp[s] && present[s]) begin
				ei[(s / 2) * 8 + p +: 4] = fin[4*s +: 4] & maskOf(ioCode[4*s +: 4]);
				eo[4*s +: 4] = bytes[s/2][p +: 4] & ~maskOf(ioCode[4*s +: 4]);
			end
		end
		chk(dpIn, ei, "input image");
		chk(fieldOut, eo, "output image");
	endtask

	initial begin
		void'($urandom(32'h27f7_a0c1));
		present = ($urandom | 32'h0000_0006) & 32'hFFFF_7FFE;
		for (int s = 0; s < 32; s++) ioCode[4*s +: 4] = 4'(s + 3);
		setp = present;
		repeat (2) @(posedge clk);
		#1 rst = 0;
		checkBcast();
		chk(diag[159:128], setp, "present map");
		chk(exchActive, 0, "idle before messages");
		sendMsg(MSG_PRM, 6);
		tick(6);
		chk(lenErrs, 1, "short parameters");
		sendMsg(MSG_PRM, 7);
		tick(6);
		chk(exchActive, 0, "parameters only");
		sendMsg(MSG_CFG, 19);
		tick(6);
		chk(lenErrs, 2, "short configuration");
		sendMsg(MSG_CFG, 20);
		tick(6);
		chk(exchActive, 1, "exchange running");
		$display("test startup done");
		repeat (3) imageRound();
		// Drop slave 2 and add slave 15 after the freeze
		present = present ^ 32'h0000_8004;
		tick(4);
		chk(diag[31:0], 32'h0000_0004, "failed slave");
		imageRound();
		// A low clock enable must swallow a restart pulse
		clkEn = 0;
		restart = 1;
		tick(2);
		restart = 0;
		tick(2);
		clkEn = 1;
		tick(2);
		chk(exchActive, 1, "restart ignored while frozen");
		$display("test freeze done");
		slow = 1;
		present = ($urandom | 32'h0000_0002) & 32'hFFFF_FFFE;
		setp = present;
		i_field_partner.seen.delete();
		restart = 1;
		tick(1);
		restart = 0;
		sendMsg(MSG_PRM, 7);
		sendMsg(MSG_CFG, 20);
		checkBcast();
		tick(6);
		chk(sawFull, 1, "queue refused when full");
		chk(exchActive, 1, "exchange after restart");
		chk(diag[31:0], 0, "no failures after restart");
		imageRound();
		$display("test restart done");
		end_of_test();
	end

	initial begin
		#200000;
		errors++;
		end_of_test();
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
endmodule
